//--- hdl/uep_ctrl.sv
// Module: endpoint control and status registers with handshake gating
`timescale 1ns/1ns
module uep_ctrl #(
    parameter int NUM_EP = uep_pkg::NUM_EP
) (
    // Clock and resets
    input  wire logic             mclk,
    input  wire logic             sys_rst,
    input  wire logic             usb_rst,
    // Special-function register access
    input  wire logic [7:0]       sfr_addr,
    input  wire logic             sfr_wr,
    input  wire logic             sfr_rd,
    input  wire logic [7:0]       sfr_wdata,
    output logic [7:0]            sfr_rdata_r,
    // Events from the packet engine
    input  wire logic             ev_valid,
    input  wire uep_pkg::uep_ev_t ev_word,
    output logic                  ev_ready,
    // Token query from the packet engine
    input  wire logic             tok_valid,
    input  wire logic [2:0]       tok_ep,
    input  wire uep_pkg::uep_tok_t tok_kind,
    input  wire logic             tok_bank,
    output logic                  hs_valid_r,
    output uep_pkg::uep_hs_t      hs_code_r,
    // Per-endpoint event pulses
    output logic [NUM_EP-1:0]     ep_event_r
);
    logic [7:0]        con_r [NUM_EP];
    logic [7:0]        con_nxt [NUM_EP];
    logic [7:0]        sta_r [NUM_EP];
    logic [7:0]        sta_nxt [NUM_EP];
    logic [3:0]        sel_r, sel_nxt;
    logic [7:0]        rdata_nxt;
    logic              hs_valid_nxt;
    uep_pkg::uep_hs_t  hs_code_nxt;
    logic [NUM_EP-1:0] ep_event_nxt;
    uep_pkg::uep_hs_t  hs_code;
    logic              sel_ok, fw_con, fw_sta, take;
    logic [7:0]        tok_con, tok_sta;

    uep_ev_if ev_bus ();

    ////////////////////////////////////////////////////////////////
    // Event buffer: the register file stalls it during firmware writes
    uep_fifo2 #(
        .WIDTH ($bits(uep_pkg::uep_ev_t)),
        .DEPTH (2)
    ) u_buf (
        .mclk     (mclk),
        .sys_rst  (sys_rst),
        .in_valid (ev_valid),
        .in_word  (ev_word),
        .in_ready (ev_ready),
        .out      (ev_bus.src)
    );

    // Draining waits out a firmware write so both never touch one flag
    assign ev_bus.ready = !sfr_wr;
    assign take         = ev_bus.valid && ev_bus.ready;

    ////////////////////////////////////////////////////////////////
    // Handshake decision on the addressed endpoint
    assign tok_con = (tok_ep < 3'(NUM_EP)) ? con_r[tok_ep] : 8'h00;
    assign tok_sta = (tok_ep < 3'(NUM_EP)) ? sta_r[tok_ep] : 8'h00;

    uep_hs u_hs (
        .tok_ep   (tok_ep),
        .tok_kind (tok_kind),
        .tok_bank (tok_bank),
        .con      (tok_con),
        .sta      (tok_sta),
        .code     (hs_code)
    );

    ////////////////////////////////////////////////////////////////
    // selected endpoint decode
    assign sel_ok = (sel_r < 4'(NUM_EP));
    assign fw_con = sfr_wr && sfr_addr == uep_pkg::CON_ADDR && sel_ok;
    assign fw_sta = sfr_wr && sfr_addr == uep_pkg::STA_ADDR && sel_ok;

    // Register file next state: firmware first, hardware events last
    always_comb begin
        logic is_iso;
        logic is_ctrl;
        logic [7:0] keep;
        is_iso  = 1'b0;
        is_ctrl = 1'b0;
        keep    = 8'h00;
        sel_nxt = sel_r;
        ep_event_nxt = '0;
        if (sfr_wr && sfr_addr == uep_pkg::SEL_ADDR) begin
            sel_nxt = sfr_wdata[3:0];
        end
        for (int i = 0; i < NUM_EP; i++) begin
            con_nxt[i] = con_r[i];
            sta_nxt[i] = sta_r[i];
            is_iso  = uep_pkg::eff_type(3'(i), con_r[i]) == uep_pkg::UEP_ISO;
            is_ctrl = uep_pkg::eff_type(3'(i), con_r[i]) == uep_pkg::UEP_CTRL;
            if (usb_rst) begin
                con_nxt[i] = (i == 0) ? uep_pkg::CON_RST_EP0 : uep_pkg::CON_RST_OTHER;
                sta_nxt[i] = uep_pkg::STA_RST;
            end else begin
                if (fw_con && sel_r == 4'(i)) begin
                    // reserved bits stay zero, toggle read-only
                    con_nxt[i] = (sfr_wdata & uep_pkg::CON_WMASK)
                               | (con_r[i] & ~uep_pkg::CON_WMASK & 8'h08);
                    if (i == 0) begin
                        con_nxt[i][1:0] = 2'(uep_pkg::UEP_CTRL);
                    end
                end
                if (fw_sta && sel_r == 4'(i)) begin
                    // direction, stall request and ready written as is
                    sta_nxt[i][uep_pkg::STA_DIR]   = sfr_wdata[uep_pkg::STA_DIR];
                    sta_nxt[i][uep_pkg::STA_STALL] = sfr_wdata[uep_pkg::STA_STALL];
                    sta_nxt[i][uep_pkg::STA_RDY]   = sfr_wdata[uep_pkg::STA_RDY];
                    // event flags only cleared by writing zero
                    keep = sfr_wdata | 8'hb0;
                    if (is_iso) begin
                        keep[uep_pkg::STA_STALL_SENT_OR_CRC_ERROR] = 1'b1;  // read-only on iso
                    end
                    sta_nxt[i] = sta_nxt[i] & keep;
                end
                if (take && ev_bus.word.ep == 3'(i)) begin
                    unique case (ev_bus.word.kind)
                        uep_pkg::EV_SETUP: begin
                            sta_nxt[i]            = uep_pkg::STA_SETUP_VAL;
                            con_nxt[i][uep_pkg::CON_TGL] = 1'b1;
                            ep_event_nxt[i]       = 1'b1;
                        end
                        uep_pkg::EV_OUT: begin
                            if (ev_bus.word.bank && i >= uep_pkg::PINGPONG_EP) begin
                                sta_nxt[i][uep_pkg::STA_B1] = 1'b1;
                            end else begin
                                sta_nxt[i][uep_pkg::STA_B0] = 1'b1;
                            end
                            con_nxt[i][uep_pkg::CON_TGL] = !ev_bus.word.pid1;
                            if (is_iso) begin
                                sta_nxt[i][uep_pkg::STA_STALL_SENT_OR_CRC_ERROR] = ev_bus.word.crc_err;
                            end
                            ep_event_nxt[i] = 1'b1;
                        end
                        uep_pkg::EV_IN_DONE: begin
                            sta_nxt[i][uep_pkg::STA_RDY]  = 1'b0;
                            sta_nxt[i][uep_pkg::STA_CMPL] = 1'b1;
                            ep_event_nxt[i] = 1'b1;
                        end
                        uep_pkg::EV_STALL_SENT: begin
                            if (!is_iso) begin
                                sta_nxt[i][uep_pkg::STA_STALL_SENT_OR_CRC_ERROR] = 1'b1;
                                ep_event_nxt[i] = 1'b1;
                            end
                        end
                    endcase
                end
                if (!is_ctrl && !is_iso) begin
                    con_nxt[i][uep_pkg::CON_DIR] = con_nxt[i][uep_pkg::CON_DIR];
                end
            end
        end
    end

    // Read data and handshake answer
    always_comb begin
        rdata_nxt = sfr_rdata_r;
        if (sfr_rd) begin
            unique case (sfr_addr)
                uep_pkg::SEL_ADDR: rdata_nxt = {4'h0, sel_r};
                uep_pkg::CON_ADDR: rdata_nxt = sel_ok ? con_r[sel_r[2:0]] : 8'h00;
                uep_pkg::STA_ADDR: rdata_nxt = sel_ok ? sta_r[sel_r[2:0]] : 8'h00;
                default:           rdata_nxt = 8'h00;
            endcase
        end
        hs_valid_nxt = tok_valid;
        hs_code_nxt  = tok_valid ? hs_code : uep_pkg::HS_NONE;
    end

    ////////////////////////////////////////////////////////////////
    // State registers
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            for (int i = 0; i < NUM_EP; i++) begin
                con_r[i] <= (i == 0) ? uep_pkg::CON_RST_EP0 : uep_pkg::CON_RST_OTHER;
                sta_r[i] <= uep_pkg::STA_RST;
            end
            sel_r       <= uep_pkg::SEL_RST;
            sfr_rdata_r <= 8'h00;
            hs_valid_r  <= 1'b0;
            hs_code_r   <= uep_pkg::HS_NONE;
            ep_event_r  <= '0;
        end else begin
            for (int i = 0; i < NUM_EP; i++) begin
                con_r[i] <= con_nxt[i];
                sta_r[i] <= sta_nxt[i];
            end
            sel_r       <= usb_rst ? uep_pkg::SEL_RST : sel_nxt;
            sfr_rdata_r <= rdata_nxt;
            hs_valid_r  <= hs_valid_nxt;
            hs_code_r   <= hs_code_nxt;
            ep_event_r  <= usb_rst ? '0 : ep_event_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Checks: helper copy of the last consumed event
    logic             take_d;
    logic             rst_d;
    uep_pkg::uep_ev_t ev_d;
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            take_d <= 1'b0;
            rst_d  <= 1'b0;
            ev_d   <= '0;
        end else begin
            take_d <= take && !usb_rst;
            rst_d  <= usb_rst;
            ev_d   <= ev_bus.word;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    chk_ep0_reset_value: assert property (usb_rst |=> con_r[0] == uep_pkg::CON_RST_EP0 && con_r[1] == 8'h00)
        else $error("endpoint control not at reset value after bus reset");
    chk_ep0_enabled: assert property (rst_d |-> con_r[0][uep_pkg::CON_EN])
        else $error("endpoint zero not enabled after reset");
    chk_reserved_zero: assert property (sfr_rd && sfr_addr == uep_pkg::CON_ADDR |=> sfr_rdata_r[6:4] == 3'h0)
        else $error("reserved control bits read nonzero");
    chk_toggle_pid: assert property (take_d && ev_d.kind == uep_pkg::EV_OUT
        |-> con_r[ev_d.ep][uep_pkg::CON_TGL] == !ev_d.pid1)
        else $error("toggle flag does not follow received PID");
    chk_ep0_control: assert property (con_r[0][1:0] == 2'b00)
        else $error("endpoint zero left control type");
    chk_setup_clears: assert property (take_d && ev_d.kind == uep_pkg::EV_SETUP
        |-> sta_r[ev_d.ep] == uep_pkg::STA_SETUP_VAL && ep_event_r[ev_d.ep])
        else $error("setup did not leave only the setup flag");
    chk_stall_answer: assert property (tok_valid && tok_kind != uep_pkg::TOK_SETUP && tok_con[uep_pkg::CON_EN]
        && tok_sta[uep_pkg::STA_STALL] |=> hs_code_r == uep_pkg::HS_STALL)
        else $error("stall request not answered with STALL");
    chk_bank0_nak: assert property (tok_valid && tok_kind == uep_pkg::TOK_OUT && !tok_bank
        && tok_con[uep_pkg::CON_EN] && !tok_sta[uep_pkg::STA_STALL] && tok_sta[uep_pkg::STA_B0]
        && uep_pkg::eff_type(tok_ep, tok_con) != uep_pkg::UEP_ISO |=> hs_code_r == uep_pkg::HS_NAK)
        else $error("full bank zero not NAKed");
    chk_in_complete: assert property (take_d && ev_d.kind == uep_pkg::EV_IN_DONE
        |-> sta_r[ev_d.ep][uep_pkg::STA_CMPL] && !sta_r[ev_d.ep][uep_pkg::STA_RDY])
        else $error("IN completion not recorded");

    cov_setup: cover property (take && ev_bus.word.kind == uep_pkg::EV_SETUP);
    cov_bank1: cover property (take && ev_bus.word.kind == uep_pkg::EV_OUT && ev_bus.word.bank);
    cov_stall: cover property (hs_code_r == uep_pkg::HS_STALL);
    cov_buf_full: cover property (!ev_ready ##1 ev_ready);
endmodule : uep_ctrl

//--- hdl/uep_ev_if.sv
// Interface: event word stream from the buffer to the register file
`timescale 1ns/1ns
interface uep_ev_if;
    logic             valid;
    logic             ready;
    uep_pkg::uep_ev_t word;
    modport src (output valid, output word, input ready);
    modport snk (input valid, input word, output ready);
endinterface : uep_ev_if

//--- hdl/uep_fifo2.sv
// Module: small event buffer between the packet engine and the register file
`timescale 1ns/1ns
module uep_fifo2 #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 2
) (
    // Clock and reset
    input  wire logic             mclk,
    input  wire logic             sys_rst,
    // Filling side
    input  wire logic             in_valid,
    input  wire logic [WIDTH-1:0] in_word,
    output logic                  in_ready,
    // Draining side
    uep_ev_if.src                 out
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [PW-1:0]    wp_r, wp_nxt, rp_r, rp_nxt;
    logic [PW:0]      cnt_r, cnt_nxt;
    logic             push, pop;

    function automatic logic [PW-1:0] inc(input logic [PW-1:0] p);
        inc = (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction : inc

    ////////////////////////////////////////////////////////////////
    // Full and empty come straight from the count flop
    assign in_ready  = (cnt_r != (PW+1)'(DEPTH));
    assign out.valid = (cnt_r != '0);
    assign out.word  = mem_r[rp_r];
    assign push      = in_valid && in_ready;
    assign pop       = out.valid && out.ready;

    // Pointer and count next state
    always_comb begin
        wp_nxt  = push ? inc(wp_r) : wp_r;
        rp_nxt  = pop ? inc(rp_r) : rp_r;
        cnt_nxt = cnt_r + (PW+1)'(push) - (PW+1)'(pop);
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            wp_r  <= '0;
            rp_r  <= '0;
            cnt_r <= '0;
        end else begin
            wp_r  <= wp_nxt;
            rp_r  <= rp_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    // Storage holds no control state, so it needs no reset
    always_ff @(posedge mclk) begin
        if (push) begin
            mem_r[wp_r] <= in_word;
        end
    end
endmodule : uep_fifo2

//--- hdl/uep_hs.sv
// Module: handshake decision for one token against one endpoint's state
`timescale 1ns/1ns
module uep_hs (
    // Token
    input  wire logic [2:0]       tok_ep,
    input  wire uep_pkg::uep_tok_t tok_kind,
    input  wire logic             tok_bank,
    // Endpoint state
    input  wire logic [7:0]       con,
    input  wire logic [7:0]       sta,
    // Answer
    output uep_pkg::uep_hs_t      code
);
    uep_pkg::uep_type_t typ;
    logic               full;

    assign typ  = uep_pkg::eff_type(tok_ep, con);
    assign full = (tok_bank && tok_ep >= 3'(uep_pkg::PINGPONG_EP)) ? sta[uep_pkg::STA_B1]
                                                                   : sta[uep_pkg::STA_B0];

    // Priority: disabled, setup, stall, then per direction
    always_comb begin
        code = uep_pkg::HS_NONE;
        if (!con[uep_pkg::CON_EN]) begin
            code = uep_pkg::HS_NONE;
        end else if (tok_kind == uep_pkg::TOK_SETUP) begin
            code = (typ == uep_pkg::UEP_CTRL) ? uep_pkg::HS_ACK : uep_pkg::HS_NONE;
        end else if (sta[uep_pkg::STA_STALL]) begin
            code = uep_pkg::HS_STALL;
        end else if (tok_kind == uep_pkg::TOK_OUT) begin
            code = (full && typ != uep_pkg::UEP_ISO) ? uep_pkg::HS_NAK : uep_pkg::HS_ACK;
        end else begin
            code = sta[uep_pkg::STA_RDY] ? uep_pkg::HS_ACK : uep_pkg::HS_NAK;
        end
    end
endmodule : uep_hs

//--- hdl/uep_pkg.sv
// Package: endpoint register map, field layout, reset values and event types
//
// Contract
// - Hardware or bus reset always leaves endpoint zero enabled.
// - Reserved control register bits always read as zero.
// - Toggle flag set on accepted DATA0, cleared on accepted DATA1.
// - Direction bit selects IN when one, OUT when zero; ignored for control. Here it is only stored; handshakes never depend on it.
// - Type field: 00 control, 01 isochronous, 10 bulk, 11 interrupt.
// - Endpoint zero always behaves as a control endpoint.
// - Control register resets to 80h for endpoint zero, 00h otherwise.
// - Ping-pong endpoints four to six set bank-one flag on stored packet.
// - Full bank NAKs further OUT packets, except on isochronous endpoints.
// - Bank-zero flag set on stored packet; later OUT to bank zero NAKed.
// - SETUP on a control endpoint is accepted even with bank zero full.
// - While stall request is set the next handshake is STALL.
// - Valid SETUP on a control endpoint clears stall request.
// - Firmware sets packet ready after loading; empty load sends zero length.
// - Packet ready cleared when sent (iso) or acknowledged; event raised.
// - Stall-sent flag set after requested STALL; firmware clears it.
// - On isochronous endpoints that flag shows CRC error of last packet.
// - Valid SETUP sets setup flag, clears all other status bits, raises event.
// - Transfer complete flag set when IN sent (iso) or acknowledged.
package uep_pkg;
    localparam int         NUM_EP        = 7;
    localparam int         PINGPONG_EP   = 4;
    // Register offsets
    localparam logic [7:0] SEL_ADDR      = 8'hc7;
    localparam logic [7:0] STA_ADDR      = 8'hce;
    localparam logic [7:0] CON_ADDR      = 8'hd4;
    // Reset values
    localparam logic [7:0] CON_RST_EP0   = 8'h80;
    localparam logic [7:0] CON_RST_OTHER = 8'h00;
    localparam logic [7:0] STA_RST       = 8'h00;
    localparam logic [3:0] SEL_RST       = 4'h0;
    // Control register layout
    localparam logic [7:0] CON_WMASK     = 8'h87;
    localparam int         CON_EN        = 7;
    localparam int         CON_TGL       = 3;
    localparam int         CON_DIR       = 2;
    // Status register layout
    localparam int         STA_DIR       = 7;
    localparam int         STA_B1        = 6;
    localparam int         STA_STALL     = 5;
    localparam int         STA_RDY       = 4;
    localparam int         STA_STALL_SENT_OR_CRC_ERROR    = 3;
    localparam int         STA_SETUP     = 2;
    localparam int         STA_B0        = 1;
    localparam int         STA_CMPL      = 0;
    localparam logic [7:0] STA_SETUP_VAL = 8'h04;

    typedef enum logic [1:0] {
        UEP_CTRL = 2'b00,
        UEP_ISO  = 2'b01,
        UEP_BULK = 2'b10,
        UEP_INTR = 2'b11
    } uep_type_t;

    typedef enum logic [1:0] {
        EV_SETUP, EV_OUT, EV_IN_DONE, EV_STALL_SENT
    } uep_ev_kind_t;

    typedef struct packed {
        logic [2:0]   ep;
        uep_ev_kind_t kind;
        logic         bank;
        logic         pid1;
        logic         crc_err;
    } uep_ev_t;

    typedef enum logic [1:0] {TOK_OUT, TOK_IN, TOK_SETUP} uep_tok_t;
    typedef enum logic [1:0] {HS_NONE, HS_ACK, HS_NAK, HS_STALL} uep_hs_t;

    // type decode
    // Effective type: endpoint zero is control whatever is stored
    function automatic uep_type_t eff_type(input logic [2:0] ep, input logic [7:0] con);
        eff_type = (ep == 3'h0) ? UEP_CTRL : uep_type_t'(con[1:0]);
    endfunction : eff_type
endpackage : uep_pkg

//--- testbench/uep_ctrl_tb.sv
// Testbench: endpoint registers, events, handshakes and buffer stall
`timescale 1ns/1ns
module uep_ctrl_tb;
    logic              mclk, sys_rst, usb_rst, sfr_wr, sfr_rd, tok_valid, tok_bank;
    logic              send, ev_valid, ev_ready, hs_valid_r;
    logic [7:0]        sfr_addr, sfr_wdata, sfr_rdata_r;
    logic [2:0]        tok_ep;
    logic [6:0]        ep_event_r;
    uep_pkg::uep_tok_t tok_kind;
    uep_pkg::uep_hs_t  hs_code_r;
    uep_pkg::uep_ev_t  ev_word, send_word;
    int                error_cnt, samples_checked;

    uep_ctrl uut (.mclk(mclk), .sys_rst(sys_rst), .usb_rst(usb_rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
        .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata_r(sfr_rdata_r), .ev_valid(ev_valid),
        .ev_word(ev_word), .ev_ready(ev_ready), .tok_valid(tok_valid), .tok_ep(tok_ep), .tok_kind(tok_kind),
        .tok_bank(tok_bank), .hs_valid_r(hs_valid_r), .hs_code_r(hs_code_r), .ep_event_r(ep_event_r));
    uep_host_model host (.mclk(mclk), .send(send), .send_word(send_word), .ev_valid(ev_valid),
        .ev_word(ev_word), .ev_ready(ev_ready));

    ////////////////////////////////////////////////////////////////////////////
    task automatic stop_test;
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : stop_test
    task automatic chk8(string name, logic [7:0] exp, logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask : chk8
    // Write strobe is one cycle; drive on the falling edge so the rising edge sees it settled
    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(negedge mclk);
        sfr_addr  <= a;
        sfr_wdata <= d;
        sfr_wr    <= 1'b1;
        @(negedge mclk);
        sfr_wr    <= 1'b0;
    endtask : wr
    task automatic rdc(string n, logic [7:0] a, logic [7:0] e);
        @(negedge mclk);
        sfr_addr <= a;
        sfr_rd   <= 1'b1;
        @(negedge mclk);
        sfr_rd   <= 1'b0;
        chk8(n, e, sfr_rdata_r);
    endtask : rdc
    task automatic tok(logic [2:0] ep, uep_pkg::uep_tok_t k, uep_pkg::uep_hs_t e);
        @(negedge mclk);
        tok_ep    <= ep;
        tok_kind  <= k;
        tok_valid <= 1'b1;
        @(negedge mclk);
        tok_valid <= 1'b0;
        chk8("handshake", {5'h1, e}, {4'h0, hs_valid_r, hs_code_r});
    endtask : tok
    // Bounded wait for the word to be taken, then time for the drain and flag update
    task automatic ev(logic [2:0] ep, uep_pkg::uep_ev_kind_t k, logic crc, bit wait_done);
        @(negedge mclk);
        send_word <= {ep, k, 1'b0, 1'b0, crc};
        send      <= 1'b1;
        @(negedge mclk);
        send      <= 1'b0;
        // Let the model's offer settle before the bounded wait looks at it
        #1;
        for (int i = 0; i < 20 && wait_done && (ev_valid !== 1'b0); i++) #50;
        if (wait_done && ev_valid !== 1'b0) begin
            error_cnt++;
            $display("CHECK FAILED event take expected 0 seen %b", ev_valid);
            stop_test;
        end
        if (wait_done) repeat (4) @(negedge mclk);
    endtask : ev

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        rdc("ep0 control", 8'hd4, 8'h80);
        rdc("ep0 status", 8'hce, 8'h00);
        wr(8'hc7, 8'h03);
        rdc("ep3 control", 8'hd4, 8'h00);
        wr(8'hd4, 8'hff);
        rdc("ep3 reserved", 8'hd4, 8'h87);
        $display("reset values done");
    endtask : t_reset
    // Writes to an unmapped place stall the drain, so the buffer fills
    task automatic t_fill;
        wr(8'hc7, 8'h01);
        wr(8'hd4, 8'h82);
        @(negedge mclk);
        sfr_addr <= 8'h00;
        sfr_wr   <= 1'b1;
        repeat (3) ev(3'h1, uep_pkg::EV_OUT, 1'b0, 1'b0);
        repeat (2) @(negedge mclk);
        chk8("buffer full", 8'h00, {7'h0, ev_ready});
        sfr_wr   <= 1'b0;
        ev(3'h1, uep_pkg::EV_OUT, 1'b0, 1'b1);
        rdc("ep1 bank0", 8'hce, 8'h02);
        rdc("ep1 toggle", 8'hd4, 8'h8a);
        tok(3'h1, uep_pkg::TOK_OUT, uep_pkg::HS_NAK);
        $display("buffer and out done");
    endtask : t_fill
    task automatic t_ep0;
        wr(8'hc7, 8'h00);
        wr(8'hd4, 8'h81);
        ev(3'h0, uep_pkg::EV_OUT, 1'b0, 1'b1);
        tok(3'h0, uep_pkg::TOK_SETUP, uep_pkg::HS_ACK);
        wr(8'hce, 8'h22);                                 // direction kept clear
        tok(3'h0, uep_pkg::TOK_IN, uep_pkg::HS_STALL);
        ev(3'h0, uep_pkg::EV_SETUP, 1'b0, 1'b1);
        rdc("ep0 setup", 8'hce, 8'h04);
        $display("control endpoint done");
    endtask : t_ep0
    task automatic t_in;
        wr(8'hc7, 8'h01);
        wr(8'hce, 8'h00);
        wr(8'hd4, 8'h86);
        wr(8'hce, 8'h10);
        rdc("ep1 ready", 8'hce, 8'h10);
        tok(3'h1, uep_pkg::TOK_IN, uep_pkg::HS_ACK);
        ev(3'h1, uep_pkg::EV_IN_DONE, 1'b0, 1'b1);
        rdc("ep1 in done", 8'hce, 8'h01);
        $display("in transfer done");
    endtask : t_in
    task automatic t_iso;
        wr(8'hc7, 8'h02);
        wr(8'hd4, 8'h81);
        ev(3'h2, uep_pkg::EV_OUT, 1'b1, 1'b1);
        rdc("ep2 crc", 8'hce, 8'h0a);
        tok(3'h2, uep_pkg::TOK_OUT, uep_pkg::HS_ACK);
        $display("isochronous done");
    endtask : t_iso
    task automatic t_busrst;
        wr(8'hc7, 8'h00);
        wr(8'hd4, 8'h00);
        @(negedge mclk);
        usb_rst <= 1'b1;
        repeat (2) @(negedge mclk);
        usb_rst <= 1'b0;
        rdc("ep0 after bus reset", 8'hd4, 8'h80);
        $display("bus reset done");
    endtask : t_busrst

    ////////////////////////////////////////////////////////////////////////////
    // Clock at 20 MHz
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    // Main sequence
    initial begin
        error_cnt = 0;
        samples_checked = 0;
        {sys_rst, usb_rst, sfr_wr, sfr_rd, tok_valid, tok_bank, send} = 7'h40;
        {sfr_addr, sfr_wdata, tok_ep} = '0;
        tok_kind  = uep_pkg::TOK_OUT;
        send_word = '0;
        repeat (12) @(negedge mclk);
        sys_rst <= 1'b0;
        t_reset;
        t_fill;
        t_ep0;
        t_in;
        t_iso;
        t_busrst;
        stop_test;
    end
endmodule : uep_ctrl_tb

//--- testbench/uep_host_model.sv
// Packet engine model: offers one event word and holds it until taken
`timescale 1ns/1ns
module uep_host_model (
    // Clock
    input  wire logic             mclk,
    // Test requests
    input  wire logic             send,
    input  wire uep_pkg::uep_ev_t send_word,
    // Event stream to the block
    output logic                  ev_valid,
    output uep_pkg::uep_ev_t      ev_word,
    input  wire logic             ev_ready
);
    logic taken;
    initial begin
        ev_valid = 1'b0;
        ev_word  = '0;
        taken    = 1'b0;
    end
    // Take is seen on the rising edge, so the word never moves before it
    always @(posedge mclk) begin
        taken <= ev_valid & ev_ready;
    end
    // A released word is inverted so a late sampler cannot match by chance
    always @(negedge mclk) begin
        if (taken) begin
            ev_valid <= 1'b0;
            ev_word  <= ~ev_word;
        end
        if (send) begin
            ev_valid <= 1'b1;
            ev_word  <= send_word;
        end
    end
endmodule : uep_host_model
